// *** design/wdt_top.sv ***
`timescale 1ns/100ps
`include "wdt_defines.svh"

// Function
// - Counter advances only on slow oscillator ticks
// - Enabled watchdog forces slow oscillator on
// - Prescaler divides by 32 or 128
// - Postscaler gives sixteen ratios 1:1 to 1:32768
// - Any device reset clears all counts
// - Completed clock switch clears all counts
// - Entering sleep or idle clears counts
// - Leaving sleep or idle clears counts
// - Clear instruction in run clears counts
// - Enabled watchdog keeps counting in sleep, idle
// - Time-out in sleep or idle wakes device
// - Hardware enable forces watchdog on always
// - Otherwise software enable bit five runs it
// - Device reset clears software enable
// - Time-out flag bit four stays until cleared
// - Window mode when bit six is zero
// - Prescale select one is 1:128, zero 1:32
// - Postscale code n divides by two power n
// - Window codes give 25, 37.5, 50, 75 percent
module wdt_top #(
    parameter int CLK_HZ     = `WDT_CLK_HZ,      // System clock rate
    parameter int SLOW_RC_HZ = `WDT_SLOW_RC_HZ,  // Slow oscillator rate
    parameter int AW         = 8                 // APB address width
) (
    input  wire logic          CLK,                        // System clock, 40 MHz
    input  wire logic          RST_N,                      // Async power-on reset, active low
    input  wire logic          PSEL,                       // APB select
    input  wire logic          PENABLE,                    // APB enable
    input  wire logic          PWRITE,                     // APB direction, high for write
    input  wire logic [AW-1:0] PADDR,                      // APB byte address
    input  wire logic [31:0]   PWDATA,                     // APB write data
    output logic      [31:0]   PRDATA,                     // APB read data
    output logic               PREADY,                     // APB ready
    output logic               PSLVERR,                    // APB error on unmapped address
    input  wire logic          DEVICE_RESET,               // Any device reset, one-cycle pulse
    input  wire logic          CLOCK_SWITCH_DONE,          // Clock switch completed, pulse
    input  wire logic          POWER_SAVE_INSTRUCTION,     // Power-save executed, pulse
    input  wire logic          POWER_SAVE_IDLE,            // With the above: high idle, low sleep
    input  wire logic          WATCHDOG_CLEAR_INSTRUCTION, // Clear instruction executed, pulse
    input  wire logic          WAKE_OTHER,                 // Wake from another source, pulse
    input  wire logic          SLOW_RC_REQ,                // Clock settings want the slow RC
    output logic               WDT_RESET_REQ,              // Device reset request, pulse
    output logic               WDT_WAKE,                   // Wake from power save, pulse
    output logic               SLOW_RC_ON,                 // Slow RC oscillator running
    output logic      [1:0]    POWER_MODE                  // Current power mode
);

    localparam int DIV = CLK_HZ / SLOW_RC_HZ;  // System clocks per slow tick

    // ==========================================================
    // Declarations
    logic [31:0]       cfg_r;                  // Configuration word
    logic [31:0]       cfg_nxt;
    logic              sw_en_r;                // Software enable
    logic              sw_en_nxt;
    logic              to_flag_r;              // Sticky time-out flag
    logic              to_flag_nxt;
    logic              sleep_flag_r;           // Sleep status flag
    logic              sleep_flag_nxt;
    logic              idle_flag_r;            // Idle status flag
    logic              idle_flag_nxt;
    wdt_pkg::wdt_mode_t mode_r;                // Power mode
    wdt_pkg::wdt_mode_t mode_nxt;
    logic [6:0]        pre_r;                  // Prescaler count
    logic [6:0]        pre_nxt;
    logic [14:0]       post_r;                 // Postscaler count
    logic [14:0]       post_nxt;
    logic              rst_req_r;              // Reset request flop
    logic              rst_req_nxt;
    logic              wake_r;                 // Wake pulse flop
    logic              wake_nxt;
    logic              rc_on_r;                // Oscillator on flop
    logic              rc_on_nxt;

    logic              slow_tick;              // Slow oscillator enable
    logic              wdt_en;                 // Watchdog running
    logic [3:0]        post_sel;               // Postscale code
    logic              pre_sel;                // Prescale select
    logic              win_dis;                // Window disable
    logic [1:0]        win_sel;                // Window size code
    logic [6:0]        pre_top;                // Prescaler terminal
    logic [14:0]       post_top;               // Postscaler terminal
    logic [22:0]       elapsed;                // Ticks since last clear
    logic [22:0]       period;                 // Ticks per period
    logic [22:0]       open_at;                // Window opening point
    logic              clear_run;              // Clear instruction in run
    logic              early_clear;            // Clear before window opens
    logic              enter_ps;               // Power-save entry
    logic              exit_ps;                // Power-save exit
    logic              timeout;                // Period expired
    logic              cnt_clear;              // Any count clear

    logic [31:0]       rd_mux;                 // Read data for PADDR
    logic              addr_hit;               // PADDR is mapped
    logic              wr_stb;                 // Register write commit
    logic [AW-1:0]     wr_addr;                // Register write address
    logic [31:0]       wr_data;                // Register write data

    // ==========================================================
    // APB front end
    wdt_apb_slave #(
        .AW       (AW)
    ) u_apb (
        .clk      (CLK),
        .rst_n    (RST_N),
        .psel     (PSEL),
        .penable  (PENABLE),
        .pwrite   (PWRITE),
        .paddr    (PADDR),
        .pwdata   (PWDATA),
        .prdata   (PRDATA),
        .pready   (PREADY),
        .pslverr  (PSLVERR),
        .rd_data  (rd_mux),
        .addr_hit (addr_hit),
        .wr_stb   (wr_stb),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data)
    );

    // ==========================================================
    // Slow oscillator tick
    wdt_tick_div #(
        .DIV   (DIV)
    ) u_slow_rc (
        .clk   (CLK),
        .rst_n (RST_N),
        .run   (rc_on_r),
        .tick  (slow_tick)
    );

    // ==========================================================
    // Field extraction
    assign post_sel = cfg_r[`WDT_CFG_POST_LSB +: 4];
    assign pre_sel  = cfg_r[`WDT_CFG_PRE_BIT];
    assign win_dis  = cfg_r[`WDT_CFG_WIN_DIS_BIT];
    assign win_sel  = cfg_r[`WDT_CFG_WIN_LSB +: 2];

    // Hardware enable overrides software enable
    assign wdt_en   = cfg_r[`WDT_CFG_HWEN_BIT] || sw_en_r;

    // ==========================================================
    // Terminal counts, elapsed time and window opening
    always_comb begin
        pre_top  = pre_sel ? `WDT_PRE_TOP_LONG : `WDT_PRE_TOP_SHORT;
        post_top = 15'((16'h0001 << post_sel) - 16'h0001);
        if (pre_sel) begin
            elapsed = {1'b0, post_r, pre_r};
            period  = 23'(24'h00_0001 << (post_sel + 5'd7));
        end else begin
            elapsed = {3'b000, post_r, pre_r[4:0]};
            period  = 23'(24'h00_0001 << (post_sel + 5'd5));
        end
        // Window opens at period minus window share
        case (win_sel)
            2'b11:   open_at = (period >> 1) + (period >> 2);
            2'b10:   open_at = (period >> 1) + (period >> 3);
            2'b01:   open_at = period >> 1;
            default: open_at = period >> 2;
        endcase
    end

    // ==========================================================
    // Events of this cycle
    always_comb begin
        enter_ps    = POWER_SAVE_INSTRUCTION && (mode_r == wdt_pkg::WDT_RUN);
        clear_run   = WATCHDOG_CLEAR_INSTRUCTION && (mode_r == wdt_pkg::WDT_RUN) && wdt_en;
        // A device reset in progress outranks an early clear
        early_clear = clear_run && !win_dis && (elapsed < open_at) && !DEVICE_RESET;
        // Expiry only on a slow tick at the final count
        timeout     = wdt_en && slow_tick && (pre_r == pre_top) && (post_r == post_top) &&
                      !DEVICE_RESET && !CLOCK_SWITCH_DONE && !clear_run && !enter_ps;
        exit_ps     = (mode_r != wdt_pkg::WDT_RUN) && (WAKE_OTHER || timeout);
        cnt_clear   = DEVICE_RESET ||
                      CLOCK_SWITCH_DONE ||
                      enter_ps ||
                      exit_ps ||
                      clear_run ||
                      timeout || !wdt_en;
    end

    // ==========================================================
    // Prescaler and postscaler counts
    always_comb begin
        pre_nxt  = pre_r;
        post_nxt = post_r;
        if (cnt_clear) begin
            pre_nxt  = 7'h00;
            post_nxt = 15'h0000;
        end else if (slow_tick) begin
            // Counts in every mode while enabled
            if (pre_r == pre_top) begin
                pre_nxt  = 7'h00;
                post_nxt = post_r + 15'h0001;
            end else begin
                pre_nxt  = pre_r + 7'h01;
            end
        end
    end

    // Register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_r  <= 7'h00;
            post_r <= 15'h0000;
        end else begin
            pre_r  <= pre_nxt;
            post_r <= post_nxt;
        end
    end

    // ==========================================================
    // Power mode sequencing
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            wdt_pkg::WDT_RUN: begin
                if (!DEVICE_RESET && enter_ps) begin
                    mode_nxt = POWER_SAVE_IDLE ? wdt_pkg::WDT_IDLE : wdt_pkg::WDT_SLEEP;
                end
            end
            wdt_pkg::WDT_SLEEP,
            wdt_pkg::WDT_IDLE: begin
                // Time-out resumes execution, no reset
                if (DEVICE_RESET || exit_ps) begin
                    mode_nxt = wdt_pkg::WDT_RUN;
                end
            end
            default: begin
                mode_nxt = wdt_pkg::WDT_RUN;
            end
        endcase
    end

    // ==========================================================
    // Outputs: reset request, wake, oscillator control
    always_comb begin
        rst_req_nxt = ((mode_r == wdt_pkg::WDT_RUN) && timeout) || early_clear;
        wake_nxt    = (mode_r != wdt_pkg::WDT_RUN) && timeout;
        rc_on_nxt   = wdt_en || SLOW_RC_REQ;
    end

    // Register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_r    <= wdt_pkg::WDT_RUN;
            rst_req_r <= 1'b0;
            wake_r    <= 1'b0;
            rc_on_r   <= 1'b0;
        end else begin
            mode_r    <= mode_nxt;
            rst_req_r <= rst_req_nxt;
            wake_r    <= wake_nxt;
            rc_on_r   <= rc_on_nxt;
        end
    end

    assign WDT_RESET_REQ = rst_req_r;
    assign WDT_WAKE      = wake_r;
    assign SLOW_RC_ON    = rc_on_r;
    assign POWER_MODE    = mode_r;

    // ==========================================================
    // Software registers; hardware sets win over software clears
    always_comb begin
        cfg_nxt        = cfg_r;
        sw_en_nxt      = sw_en_r;
        to_flag_nxt    = to_flag_r;
        sleep_flag_nxt = sleep_flag_r;
        idle_flag_nxt  = idle_flag_r;
        if (wr_stb && (wr_addr == AW'(`WDT_OFS_CONFIG))) begin
            cfg_nxt = {22'h00_0000, wr_data[9:8], wr_data[7:6], 1'b0, wr_data[4:0]};
        end
        if (wr_stb && (wr_addr == AW'(`WDT_OFS_RSTCTL))) begin
            sw_en_nxt      = wr_data[`WDT_RCS_SWEN_BIT];
            to_flag_nxt    = to_flag_r && wr_data[`WDT_RCS_TO_BIT];
            sleep_flag_nxt = sleep_flag_r && wr_data[`WDT_RCS_SLEEP_BIT];
            idle_flag_nxt  = idle_flag_r && wr_data[`WDT_RCS_IDLE_BIT];
        end
        if (DEVICE_RESET) begin
            sw_en_nxt = 1'b0;
        end
        if (timeout || early_clear) begin
            to_flag_nxt = 1'b1;
        end
        // Status flags left set after a wake
        if (enter_ps && !DEVICE_RESET) begin
            sleep_flag_nxt = sleep_flag_nxt || !POWER_SAVE_IDLE;
            idle_flag_nxt  = idle_flag_nxt || POWER_SAVE_IDLE;
        end
    end

    // Register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_r        <= `WDT_CFG_RESET;
            sw_en_r      <= 1'b0;
            to_flag_r    <= 1'b0;
            sleep_flag_r <= 1'b0;
            idle_flag_r  <= 1'b0;
        end else begin
            cfg_r        <= cfg_nxt;
            sw_en_r      <= sw_en_nxt;
            to_flag_r    <= to_flag_nxt;
            sleep_flag_r <= sleep_flag_nxt;
            idle_flag_r  <= idle_flag_nxt;
        end
    end

    // ==========================================================
    // Read decode
    always_comb begin
        rd_mux   = 32'h0000_0000;
        addr_hit = 1'b1;
        case (PADDR)
            AW'(`WDT_OFS_CONFIG): begin
                rd_mux = cfg_r;
            end
            AW'(`WDT_OFS_RSTCTL): begin
                rd_mux[`WDT_RCS_SWEN_BIT]  = sw_en_r;
                rd_mux[`WDT_RCS_TO_BIT]    = to_flag_r;
                rd_mux[`WDT_RCS_SLEEP_BIT] = sleep_flag_r;
                rd_mux[`WDT_RCS_IDLE_BIT]  = idle_flag_r;
            end
            AW'(`WDT_OFS_COUNT): begin
                rd_mux[`WDT_CNT_PRE_LSB +: 7]   = pre_r;
                rd_mux[`WDT_CNT_POST_LSB +: 15] = post_r;
                rd_mux[`WDT_CNT_MODE_LSB +: 2]  = mode_r;
                rd_mux[`WDT_CNT_EN_BIT]         = wdt_en;
                rd_mux[`WDT_CNT_RC_ON_BIT]      = rc_on_r;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

endmodule : wdt_top

// *** design/wdt_defines.svh ***
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================================
// Clock rates
`define WDT_CLK_HZ             40_000_000    // System clock rate in Hz
`define WDT_SLOW_RC_HZ         32_000        // Nominal slow RC oscillator rate in Hz

// ==========================================================
// Register byte offsets
`define WDT_OFS_CONFIG         8'h00         // Watchdog configuration word
`define WDT_OFS_RSTCTL         8'h04         // Reset control and status
`define WDT_OFS_COUNT          8'h08         // Live count readback, read only

// ==========================================================
// Configuration word fields
`define WDT_CFG_POST_LSB       0             // Postscale select, 4 bits
`define WDT_CFG_PRE_BIT        4             // Prescale select
`define WDT_CFG_WIN_DIS_BIT    6             // Window disable
`define WDT_CFG_HWEN_BIT       7             // Hardware watchdog enable
`define WDT_CFG_WIN_LSB        8             // Window size select, 2 bits
`define WDT_CFG_RESET          32'h0000_0040 // Non-window, software enabled, 1:32, 1:1

// ==========================================================
// Reset control and status fields
`define WDT_RCS_IDLE_BIT       2             // Idle status flag
`define WDT_RCS_SLEEP_BIT      3             // Sleep status flag
`define WDT_RCS_TO_BIT         4             // Sticky time-out flag
`define WDT_RCS_SWEN_BIT       5             // Software watchdog enable

// ==========================================================
// Count readback fields
`define WDT_CNT_PRE_LSB        0             // Prescaler count, 7 bits
`define WDT_CNT_POST_LSB       8             // Postscaler count, 15 bits
`define WDT_CNT_MODE_LSB       24            // Power mode, 2 bits
`define WDT_CNT_EN_BIT         26            // Watchdog running
`define WDT_CNT_RC_ON_BIT      27            // Slow RC oscillator on

// ==========================================================
// Prescaler terminal counts
`define WDT_PRE_TOP_SHORT      7'h1F         // Divide by 32
`define WDT_PRE_TOP_LONG       7'h7F         // Divide by 128

`endif

// *** design/wdt_pkg.sv ***
// ==========================================================
// Shared types
package wdt_pkg;

    // Device power mode as seen by the watchdog
    typedef enum logic [1:0] {
        WDT_RUN,
        WDT_SLEEP,
        WDT_IDLE
    } wdt_mode_t;

endpackage : wdt_pkg

// *** design/wdt_tick_div.sv ***
`timescale 1ns/100ps

// ==========================================================
// Slow oscillator model: one-cycle tick every DIV clocks
module wdt_tick_div #(
    parameter int DIV = 1250                 // System clocks per slow tick
) (
    input  wire logic clk,                   // System clock
    input  wire logic rst_n,                 // Async reset, active low
    input  wire logic run,                   // Oscillator running
    output logic      tick                   // One-cycle slow clock enable
);

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_r;                    // Cycles left to next tick
    logic [CW-1:0] cnt_nxt;
    logic          tick_r;                   // Registered tick
    logic          tick_nxt;

    // ==========================================================
    // Next count; a stopped oscillator restarts from a full period
    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!run) begin
            cnt_nxt = CW'(DIV - 1);
        end else if (cnt_r == '0) begin
            cnt_nxt  = CW'(DIV - 1);
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    // Register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : wdt_tick_div

// *** design/wdt_apb_slave.sv ***
`timescale 1ns/100ps

// ==========================================================
// APB slave front end, one access cycle, registered read data
module wdt_apb_slave #(
    parameter int AW = 8                     // Address width
) (
    input  wire logic          clk,          // System clock
    input  wire logic          rst_n,        // Async reset, active low
    input  wire logic          psel,         // APB select
    input  wire logic          penable,      // APB enable
    input  wire logic          pwrite,       // APB direction
    input  wire logic [AW-1:0] paddr,        // APB address
    input  wire logic [31:0]   pwdata,       // APB write data
    output logic      [31:0]   prdata,       // APB read data
    output logic               pready,       // APB ready
    output logic               pslverr,      // APB error
    input  wire logic [31:0]   rd_data,      // Read mux for paddr
    input  wire logic          addr_hit,     // paddr is mapped
    output logic               wr_stb,       // Write commit pulse
    output logic      [AW-1:0] wr_addr,      // Write address
    output logic      [31:0]   wr_data       // Write data
);

    logic        ready_r;                    // Setup seen, access may finish
    logic        ready_nxt;
    logic        err_r;                      // Latched decode error
    logic        err_nxt;
    logic [31:0] prdata_r;                   // Read data flop
    logic [31:0] prdata_nxt;
    logic        setup;                      // Setup phase
    logic        access;                     // Access phase

    // ==========================================================
    // Capture decode and read data in setup, finish in access
    always_comb begin
        setup      = psel && !penable;
        access     = psel && penable;
        ready_nxt  = ready_r;
        err_nxt    = err_r;
        prdata_nxt = prdata_r;
        if (setup) begin
            ready_nxt  = 1'b1;
            err_nxt    = !addr_hit;
            prdata_nxt = (!pwrite && addr_hit) ? rd_data : 32'h0000_0000;
        end else if (access && ready_r) begin
            ready_nxt = 1'b0;
        end
    end

    // Register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_r  <= 1'b0;
            err_r    <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            ready_r  <= ready_nxt;
            err_r    <= err_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // Handshake outputs
    assign pready  = psel && penable && ready_r;
    assign pslverr = pready && err_r;
    assign prdata  = prdata_r;
    assign wr_stb  = pready && pwrite && !err_r;
    assign wr_addr = paddr;
    assign wr_data = pwdata;

endmodule : wdt_apb_slave

// *** verification/wdt_chk_sva.sv ***
`timescale 1ns/100ps
// ==============================
// Port checker for the watchdog
module wdt_chk (
    input wire logic       CLK, // Clock
    input wire logic       RST_N, // Reset
    input wire logic       PENABLE, // Access
    input wire logic [7:0] PADDR, // Address
    input wire logic       PREADY, // Ready
    input wire logic       PSLVERR, // Error
    input wire logic       DEVICE_RESET, // Reset in
    input wire logic       POWER_SAVE_INSTRUCTION, // Sleep in
    input wire logic       WDT_RESET_REQ, // Reset out
    input wire logic       WDT_WAKE, // Wake out
    input wire logic [1:0] POWER_MODE // Mode
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_rdy; PENABLE |-> PREADY; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_idl; !PENABLE |-> !PREADY && !PSLVERR; endproperty
    a_idl: assert property (p_idl) else $error("stray ready");
    property p_err; PREADY |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08}); endproperty
    a_err: assert property (p_err) else $error("bad error");
    property p_pls; WDT_RESET_REQ || WDT_WAKE |=> !WDT_RESET_REQ && !WDT_WAKE; endproperty
    a_pls: assert property (p_pls) else $error("long pulse");
    property p_run; WDT_RESET_REQ |-> $past(POWER_MODE) == 2'h0; endproperty
    a_run: assert property (p_run) else $error("reset not in run");
    property p_wak; WDT_WAKE |-> $past(POWER_MODE) != 2'h0; endproperty
    a_wak: assert property (p_wak) else $error("wake in run");
    property p_ent; POWER_SAVE_INSTRUCTION && POWER_MODE == 2'h0 && !DEVICE_RESET |=> POWER_MODE != 2'h0; endproperty
    a_ent: assert property (p_ent) else $error("no entry");
    property p_dev; DEVICE_RESET |=> POWER_MODE == 2'h0 && !WDT_RESET_REQ && !WDT_WAKE; endproperty
    a_dev: assert property (p_dev) else $error("reset ignored");
endmodule : wdt_chk
bind wdt_top wdt_chk u_chk (.*);

// *** verification/wdt_tb_top.sv ***
`timescale 1ns/100ps
// ==============================
// Watchdog bench
module wdt_tb_top;
    localparam int DV = 4; // Clocks per tick
    logic        CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, WDT_RESET_REQ, WDT_WAKE, SLOW_RC_ON; // Pins
    logic        DEVICE_RESET, CLOCK_SWITCH_DONE, POWER_SAVE_INSTRUCTION, POWER_SAVE_IDLE, WAKE_OTHER; // Events
    logic        WATCHDOG_CLEAR_INSTRUCTION, SLOW_RC_REQ; // Clear, RC
    logic [1:0]  POWER_MODE; // Mode
    logic [7:0]  PADDR; // Address
    logic [31:0] PWDATA, PRDATA; // Data
    int          err_total, total_checks, n; // Counters
    wdt_top #(.SLOW_RC_HZ(40_000_000 / DV)) uut (.*);
    initial forever #12.5 CLK = ~CLK; // 40 MHz
    task chk(input logic [31:0] got, input logic [31:0] exp); // Compare
        total_checks++;
        if (got !== exp) $display("BAD t=%0t got %h exp %h", $time, got, exp);
        if (got !== exp) err_total++;
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d); // Write d, or read expecting d
        @(posedge CLK);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge CLK);
        PENABLE <= 1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        if (!w) chk(PRDATA, d);
        chk(PSLVERR, a > 8'h08); // Error only off the register map
        {PSEL, PENABLE} <= 2'h0;
    endtask : apb
    task tmo(input logic [11:0] cfg, input logic sw, input logic [2:0] ev, input int exp); // Event, time-out
        apb(1, 8'h00, 32'(cfg));
        apb(1, 8'h04, 32'(sw) << 5);
        repeat (40) @(posedge CLK);
        chk(SLOW_RC_ON, 1);
        {WATCHDOG_CLEAR_INSTRUCTION, CLOCK_SWITCH_DONE, POWER_SAVE_INSTRUCTION} <= ev;
        @(posedge CLK);
        {WATCHDOG_CLEAR_INSTRUCTION, CLOCK_SWITCH_DONE, POWER_SAVE_INSTRUCTION} <= 3'h0;
        for (n = 0; n < 3000 && !WDT_RESET_REQ && !WDT_WAKE; n++) @(posedge CLK);
        chk(n > exp - 12 && n < exp + 12, 1);
        DEVICE_RESET <= WDT_RESET_REQ;
        @(posedge CLK);
        DEVICE_RESET <= 0;
        $display("test done %0d", n);
    endtask : tmo
    task end_of_test; // Verdict
        $display("checks %0d bad %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    initial begin // Sequences
        {CLK, RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, DEVICE_RESET, CLOCK_SWITCH_DONE, total_checks} = 0;
        {POWER_SAVE_INSTRUCTION, POWER_SAVE_IDLE, WATCHDOG_CLEAR_INSTRUCTION, WAKE_OTHER, SLOW_RC_REQ, err_total} = 0;
        repeat (5) @(posedge CLK);
        RST_N <= 1;
        apb(0, 8'h00, 32'h0000_0040);
        apb(0, 8'h04, 32'h0000_0000);
        apb(0, 8'h0C, 32'h0000_0000);
        chk(SLOW_RC_ON, 0);
        tmo(12'h040, 1, 3'h4, 32 * DV);
        tmo(12'h051, 1, 3'h2, 256 * DV);
        tmo(12'h0C0, 0, 3'h4, 32 * DV);
        tmo(12'h040, 1, 3'h1, 32 * DV);
        chk(POWER_MODE, 0);
        apb(0, 8'h08, 32'h0C00_0000);
        POWER_SAVE_IDLE <= 1; // Idle entry, woken by another source
        POWER_SAVE_INSTRUCTION <= 1;
        @(posedge CLK);
        POWER_SAVE_INSTRUCTION <= 0;
        @(posedge CLK);
        chk(POWER_MODE, 2);
        WAKE_OTHER <= 1;
        @(posedge CLK);
        WAKE_OTHER <= 0;
        @(posedge CLK);
        chk(POWER_MODE, 0);
        $display("test done idle wake");
        apb(0, 8'h04, 32'h0000_003C);
        tmo(12'h300, 1, 3'h4, 1);
        apb(0, 8'h04, 32'h0000_0010);
        end_of_test;
    end
    initial begin // Hang guard
        #200_000;
        err_total++;
        end_of_test;
    end
endmodule : wdt_tb_top
